/* hdl/pafm_params.svh */
`ifndef PAFM_PARAMS_SVH
`define PAFM_PARAMS_SVH
// Line count and register layout
`define PAFM_LINES 28
`define PAFM_OFS_OUT_DATA 8'h00
`define PAFM_OFS_CFG_LOW 8'h04
`define PAFM_OFS_CFG_MID 8'h08
`define PAFM_OFS_CFG_HIGH 8'h0c
`define PAFM_OFS_PULLUP_EN 8'h10
`define PAFM_OFS_PIN_IN 8'h14
`define PAFM_OFS_AF_SEL 8'h18
// Reset values: every line bidirectional open drain, P3.7 alternate push-pull
`define PAFM_OUT_DATA_RST 28'hfff_ffff
`define PAFM_CFG_LOW_RST 28'h002_0000
`define PAFM_CFG_MID_RST 28'h002_0000
`define PAFM_CFG_HIGH_RST 28'h000_0000
`define PAFM_AF_SEL_RST 4'h0
`define PAFM_PULLUP_MASK 28'h002_0000
`define PAFM_RST_OE_MASK 28'h002_0000
// Configuration codes {high, mid, low}
`define PAFM_CFG_BID_OD 3'h0
`define PAFM_CFG_OUT_PP 3'h1
`define PAFM_CFG_BID_OD_CMOS 3'h2
`define PAFM_CFG_AF_PP 3'h3
`define PAFM_CFG_IN_CMOS 3'h4
`define PAFM_CFG_IN_TTL 3'h5
`define PAFM_CFG_AF_OD 3'h6
`define PAFM_CFG_ANALOG 3'h7
// Flat line index of each documented pin
`define PAFM_IX_P0_2 2
`define PAFM_IX_P2_0 8
`define PAFM_IX_P2_1 9
`define PAFM_IX_P2_2 10
`define PAFM_IX_P2_3 11
`define PAFM_IX_P2_4 12
`define PAFM_IX_P2_5 13
`define PAFM_IX_P3_7 17
`define PAFM_IX_P4_0 18
`define PAFM_IX_P4_3 21
`define PAFM_IX_P4_7 25
`define PAFM_IX_P5_0 26
`define PAFM_IX_P5_1 27
// Fields of the alternate-select register
`define PAFM_SEL_P37 0
`define PAFM_SEL_P43_LO 1
`define PAFM_SEL_P43_HI 2
`define PAFM_SEL_P47 3
`endif

/* hdl/pafm_pkg.sv */
package pafm_pkg;
  // One line's three configuration bits
  typedef logic [2:0] pafm_cfg_t;
  // Which alternate output owns P4.3
  typedef enum logic [1:0] {P43_PWM, P43_TRANSLUCENCY, P43_HALFTONE} pafm_p43_sel_t;
endpackage

/* hdl/pafm_pin_cell.sv */
`timescale 1ns/1ps
`include "pafm_params.svh"
module pafm_pin_cell import pafm_pkg::*; #(
  parameter bit PULLUP_OK = 1'b0, // Line has a real weak pull-up
  parameter bit SCHMITT = 1'b0, // Line has a fixed Schmitt input
  parameter bit RST_OE = 1'b0 // Drive enable held during reset
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pafm_cfg_t cfg_i, // Configuration code of this line
  input wire logic gpio_i, // Software output data
  input wire logic af_out_i, // Peripheral output value
  input wire logic af_oe_i, // Peripheral wants to drive
  input wire logic pullup_en_i, // Software pull-up enable
  input wire logic pad_i, // Asynchronous pad level
  output logic pad_o,
  output logic pad_oe_o,
  output logic pullup_o,
  output logic cmos_o,
  output logic analog_o,
  output logic din_o // Filtered digital input, low on analog lines
);
  logic s1_r, s2_r, s3_r; // Input synchroniser chain
  logic out_nxt, oe_nxt, cmos_nxt;

  // Drive and threshold decode per code; registered below so a config change
  // reaches the pad one cycle later with no decode glitch
  always_comb begin
    out_nxt = 1'b0;
    oe_nxt = 1'b0;
    cmos_nxt = 1'b0;
    unique case (cfg_i)
      `PAFM_CFG_BID_OD: oe_nxt = ~gpio_i;
      `PAFM_CFG_BID_OD_CMOS: begin
        oe_nxt = ~gpio_i;
        cmos_nxt = 1'b1;
      end
      `PAFM_CFG_OUT_PP: begin
        out_nxt = gpio_i;
        oe_nxt = 1'b1;
      end
      `PAFM_CFG_AF_PP: begin
        out_nxt = af_out_i;
        oe_nxt = af_oe_i;
      end
      `PAFM_CFG_AF_OD: oe_nxt = af_oe_i & ~af_out_i;
      `PAFM_CFG_IN_CMOS: cmos_nxt = 1'b1;
      `PAFM_CFG_IN_TTL: cmos_nxt = 1'b0;
      `PAFM_CFG_ANALOG: cmos_nxt = 1'b0;
    endcase
  end

  // Pad drive registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_o <= 1'b0;
      pad_oe_o <= RST_OE;
      cmos_o <= 1'b0;
      analog_o <= 1'b0;
      pullup_o <= 1'b0;
    end else begin
      pad_o <= out_nxt;
      pad_oe_o <= oe_nxt;
      cmos_o <= cmos_nxt & ~SCHMITT;
      analog_o <= (cfg_i == `PAFM_CFG_ANALOG);
      pullup_o <= pullup_en_i & PULLUP_OK;
    end
  end

  // Three-flop input; a change counts once flops two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      din_o <= 1'b0;
    end else begin
      s1_r <= pad_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (cfg_i == `PAFM_CFG_ANALOG) begin
        din_o <= 1'b0;
      end else if (s2_r == s3_r) begin
        din_o <= s3_r;
      end
    end
  end
endmodule

/* hdl/pafm_top.sv */
`timescale 1ns/1ps
`include "pafm_params.svh"
module pafm_top import pafm_pkg::*; (
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  // AHB-Lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // Pads, flat index: P0[7:0], P2[5:0], P3[7:4], P4[7:0], P5[1:0]
  input wire logic [27:0] PAD_IN_I,
  output logic [27:0] PAD_OUT_O,
  output logic [27:0] PAD_OE_O,
  output logic [27:0] PAD_PULLUP_O,
  output logic [27:0] PAD_CMOS_O,
  output logic [27:0] PAD_ANALOG_O,
  // Peripheral outputs toward pins
  input wire logic [7:0] PULSE_WIDTH_OUT_I,
  input wire logic TUNING_VOLTAGE_OUT_1_I,
  input wire logic TUNING_VOLTAGE_OUT_2_I,
  input wire logic TRANSLUCENCY_OUT_I,
  input wire logic HALFTONE_OUT_I,
  input wire logic TIMER_OUT_I,
  input wire logic INTERNAL_RESET_OUT_I,
  input wire logic COMPOSITE_SYNC_OUT_I,
  input wire logic SPI_CLK_I,
  input wire logic SPI_DOUT_I,
  input wire logic SPI_DOUT_EN_I,
  // Peripheral enables for implicit inputs
  input wire logic [7:0] EXT_IRQ_EN_I,
  input wire logic NMI_EN_I,
  input wire logic TRIGGER_EN_I,
  input wire logic SPI_EN_I,
  // Inputs toward peripherals
  output logic [7:0] EXT_IRQ_O,
  output logic NMI_O,
  output logic CONVERTER_TRIGGER_IN_O,
  output logic SPI_DIN_O,
  output logic [3:0] ANALOG_IN_SEL_O
);
  // Software registers
  logic [27:0] out_data_r; // Output data per line
  logic [27:0] cfg_low_r; // Low configuration bit per line
  logic [27:0] cfg_mid_r; // Middle configuration bit per line
  logic [27:0] cfg_high_r; // High configuration bit per line
  logic [27:0] pullup_en_r; // Pull-up request per line
  logic [3:0] af_sel_r; // Owner choice on shared output pins
  // Bus address phase capture
  logic wr_pend_r; // Write data phase pending
  logic [7:0] wr_addr_r; // Byte offset of pending write
  logic [31:0] rdata_nxt;
  logic take_req;
  // Per-line alternate output nets
  logic [27:0] af_out; // Selected alternate output value
  logic [27:0] af_oe; // Selected alternate drive request
  logic [27:0] din; // Filtered digital input per line
  pafm_p43_sel_t p43_sel;

  // Zero-wait slave: never stretches, always answers OKAY
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  // Only word transfers are expected; HSIZE is taken but not checked
  assign take_req = HSEL_I & HTRANS_I[1] & HREADY_I;

  // Address phase: latch write target, prepare read data
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= take_req & HWRITE_I;
      wr_addr_r <= HADDR_I[7:0];
    end
  end

  // Read mux; unmapped offsets and upper bits read as zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (HADDR_I[7:0])
      `PAFM_OFS_OUT_DATA: rdata_nxt = {4'h0, out_data_r};
      `PAFM_OFS_CFG_LOW: rdata_nxt = {4'h0, cfg_low_r};
      `PAFM_OFS_CFG_MID: rdata_nxt = {4'h0, cfg_mid_r};
      `PAFM_OFS_CFG_HIGH: rdata_nxt = {4'h0, cfg_high_r};
      `PAFM_OFS_PULLUP_EN: rdata_nxt = {4'h0, pullup_en_r & `PAFM_PULLUP_MASK};
      `PAFM_OFS_PIN_IN: rdata_nxt = {4'h0, din};
      `PAFM_OFS_AF_SEL: rdata_nxt = {28'h000_0000, af_sel_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Read data is sampled in the address phase, so it is a flop output;
  // a read right behind a write to the same word sees the old value
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      HRDATA_O <= 32'h0000_0000;
    end else if (take_req & ~HWRITE_I) begin
      HRDATA_O <= rdata_nxt;
    end
  end

  // Data phase write into the line registers
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      out_data_r <= `PAFM_OUT_DATA_RST;
      cfg_low_r <= `PAFM_CFG_LOW_RST;
      cfg_mid_r <= `PAFM_CFG_MID_RST;
      cfg_high_r <= `PAFM_CFG_HIGH_RST;
      pullup_en_r <= 28'h000_0000;
      af_sel_r <= `PAFM_AF_SEL_RST;
    end else if (wr_pend_r) begin
      unique case (wr_addr_r)
        `PAFM_OFS_OUT_DATA: out_data_r <= HWDATA_I[27:0];
        `PAFM_OFS_CFG_LOW: cfg_low_r <= HWDATA_I[27:0];
        `PAFM_OFS_CFG_MID: cfg_mid_r <= HWDATA_I[27:0];
        `PAFM_OFS_CFG_HIGH: cfg_high_r <= HWDATA_I[27:0];
        `PAFM_OFS_PULLUP_EN: pullup_en_r <= HWDATA_I[27:0];
        `PAFM_OFS_AF_SEL: af_sel_r <= HWDATA_I[3:0];
        default: ; // Unmapped or read-only: write ignored
      endcase
    end
  end

  // Shared-pin owner decode; an illegal code falls back to PWM
  always_comb begin
    unique case (af_sel_r[`PAFM_SEL_P43_HI:`PAFM_SEL_P43_LO])
      2'h1: p43_sel = P43_TRANSLUCENCY;
      2'h2: p43_sel = P43_HALFTONE;
      default: p43_sel = P43_PWM;
    endcase
  end

  // Alternate output routing; each pin takes exactly one source
  always_comb begin
    af_out = out_data_r; // Lines with no alternate output echo their data
    af_oe = 28'hfff_ffff;
    for (int i = 0; i < 8; i++) begin
      af_out[`PAFM_IX_P4_0 + i] = PULSE_WIDTH_OUT_I[i];
    end
    unique case (p43_sel)
      P43_TRANSLUCENCY: af_out[`PAFM_IX_P4_3] = TRANSLUCENCY_OUT_I;
      P43_HALFTONE: af_out[`PAFM_IX_P4_3] = HALFTONE_OUT_I;
      P43_PWM: af_out[`PAFM_IX_P4_3] = PULSE_WIDTH_OUT_I[3];
    endcase
    if (af_sel_r[`PAFM_SEL_P47]) begin
      af_out[`PAFM_IX_P4_7] = TIMER_OUT_I;
    end
    if (af_sel_r[`PAFM_SEL_P37]) begin
      af_out[`PAFM_IX_P3_7] = COMPOSITE_SYNC_OUT_I;
    end else begin
      af_out[`PAFM_IX_P3_7] = INTERNAL_RESET_OUT_I;
    end
    af_out[`PAFM_IX_P2_3] = TUNING_VOLTAGE_OUT_1_I;
    af_out[`PAFM_IX_P2_5] = TUNING_VOLTAGE_OUT_2_I;
    af_out[`PAFM_IX_P5_0] = SPI_CLK_I;
    af_out[`PAFM_IX_P5_1] = SPI_DOUT_I;
    // Shared data line releases the pad while receiving
    af_oe[`PAFM_IX_P5_1] = SPI_DOUT_EN_I;
  end

  // One cell per line, with per-line pad style
  for (genvar g = 0; g < `PAFM_LINES; g++) begin : g_line
    pafm_pin_cell #(
      // Pick this line's bit from each mask as a one-bit flag
      .PULLUP_OK(((`PAFM_PULLUP_MASK >> g) & 28'h000_0001) != 28'h000_0000),
      .SCHMITT(g == `PAFM_IX_P2_0 || g == `PAFM_IX_P2_1),
      .RST_OE(((`PAFM_RST_OE_MASK >> g) & 28'h000_0001) != 28'h000_0000)
    ) u_cell (
      .clk_i(CORE_CLK_I),
      .rst_i(SYS_RST_I),
      .cfg_i({cfg_high_r[g], cfg_mid_r[g], cfg_low_r[g]}),
      .gpio_i(out_data_r[g]),
      .af_out_i(af_out[g]),
      .af_oe_i(af_oe[g]),
      .pullup_en_i(pullup_en_r[g]),
      .pad_i(PAD_IN_I[g]),
      .pad_o(PAD_OUT_O[g]),
      .pad_oe_o(PAD_OE_O[g]),
      .pullup_o(PAD_PULLUP_O[g]),
      .cmos_o(PAD_CMOS_O[g]),
      .analog_o(PAD_ANALOG_O[g]),
      .din_o(din[g])
    );
  end

  // Implicit digital inputs: registered, so routed from the cycle after the peripheral is enabled (SPI data only while not
  // transmitting); any line code passes them except analog, which blocks them
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      EXT_IRQ_O <= 8'h00;
      NMI_O <= 1'b0;
      CONVERTER_TRIGGER_IN_O <= 1'b0;
      SPI_DIN_O <= 1'b0;
    end else begin
      EXT_IRQ_O[7] <= EXT_IRQ_EN_I[7] & din[`PAFM_IX_P2_0];
      EXT_IRQ_O[5] <= EXT_IRQ_EN_I[5] & din[`PAFM_IX_P2_1];
      EXT_IRQ_O[0] <= EXT_IRQ_EN_I[0] & din[`PAFM_IX_P2_2];
      EXT_IRQ_O[6] <= EXT_IRQ_EN_I[6] & din[`PAFM_IX_P2_3];
      EXT_IRQ_O[4] <= EXT_IRQ_EN_I[4] & din[`PAFM_IX_P2_5];
      EXT_IRQ_O[2] <= EXT_IRQ_EN_I[2] & din[`PAFM_IX_P5_0];
      EXT_IRQ_O[1] <= 1'b0; // No pin carries these two
      EXT_IRQ_O[3] <= 1'b0;
      NMI_O <= NMI_EN_I & din[`PAFM_IX_P2_4];
      CONVERTER_TRIGGER_IN_O <= TRIGGER_EN_I & din[`PAFM_IX_P4_7];
      SPI_DIN_O <= SPI_EN_I & ~SPI_DOUT_EN_I & din[`PAFM_IX_P5_1];
    end
  end

  // Converter channel switches follow the explicit analog code only
  assign ANALOG_IN_SEL_O[0] = PAD_ANALOG_O[`PAFM_IX_P2_1];
  assign ANALOG_IN_SEL_O[1] = PAD_ANALOG_O[`PAFM_IX_P2_2];
  assign ANALOG_IN_SEL_O[2] = PAD_ANALOG_O[`PAFM_IX_P2_5];
  assign ANALOG_IN_SEL_O[3] = PAD_ANALOG_O[`PAFM_IX_P0_2];

  // Checks
  a_reset_defaults: assert property (@(posedge CORE_CLK_I)
    SYS_RST_I |=> PAD_OE_O == `PAFM_RST_OE_MASK && PAD_CMOS_O == 28'h000_0000
      && PAD_PULLUP_O == 28'h000_0000)
    else $error("pad state wrong right after reset");
  a_reset_codes: assert property (@(posedge CORE_CLK_I)
    SYS_RST_I |=> ##1 (cfg_low_r == `PAFM_CFG_LOW_RST && cfg_mid_r == `PAFM_CFG_MID_RST
      && cfg_high_r == 28'h000_0000) || $past(wr_pend_r))
    else $error("configuration not at reset code");
  a_pullup_only: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (PAD_PULLUP_O & ~`PAFM_PULLUP_MASK) == 28'h000_0000
      && (PAD_PULLUP_O[`PAFM_IX_P3_7] == $past(pullup_en_r[`PAFM_IX_P3_7])))
    else $error("pull-up on a line without one");
  a_schmitt_fixed: assert property (@(posedge CORE_CLK_I)
    PAD_CMOS_O[`PAFM_IX_P2_1:`PAFM_IX_P2_0] == 2'b00)
    else $error("threshold selected on Schmitt line");
  a_pwm_drive: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    {cfg_high_r[`PAFM_IX_P4_0], cfg_mid_r[`PAFM_IX_P4_0], cfg_low_r[`PAFM_IX_P4_0]}
      == `PAFM_CFG_AF_PP |=> PAD_OE_O[`PAFM_IX_P4_0]
      && PAD_OUT_O[`PAFM_IX_P4_0] == $past(PULSE_WIDTH_OUT_I[0]))
    else $error("PWM channel 0 not on its pin");
  a_analog_gate: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    ##1 ANALOG_IN_SEL_O[0] == ($past({cfg_high_r[`PAFM_IX_P2_1],
      cfg_mid_r[`PAFM_IX_P2_1], cfg_low_r[`PAFM_IX_P2_1]}) == `PAFM_CFG_ANALOG))
    else $error("converter switch disagrees with code");
  a_irq_enable: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    !EXT_IRQ_EN_I[7] |=> !EXT_IRQ_O[7])
    else $error("interrupt passed while disabled");
  a_trig_input: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    {cfg_high_r[`PAFM_IX_P4_7], cfg_mid_r[`PAFM_IX_P4_7], cfg_low_r[`PAFM_IX_P4_7]}
      == `PAFM_CFG_IN_TTL |=> !PAD_OE_O[`PAFM_IX_P4_7] && !PAD_CMOS_O[`PAFM_IX_P4_7])
    else $error("trigger line not a TTL input");
  a_sync_select: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    {cfg_high_r[`PAFM_IX_P3_7], cfg_mid_r[`PAFM_IX_P3_7], cfg_low_r[`PAFM_IX_P3_7]}
      == `PAFM_CFG_AF_PP && af_sel_r[`PAFM_SEL_P37]
      |=> PAD_OUT_O[`PAFM_IX_P3_7] == $past(COMPOSITE_SYNC_OUT_I))
    else $error("sync output not on P3.7");
  a_spi_release: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    !SPI_DOUT_EN_I |=> !PAD_OE_O[`PAFM_IX_P5_1] || !$past(cfg_high_r[`PAFM_IX_P5_1]))
    else $error("data line driven while receiving");
endmodule

/* test/pafm_board.sv */
`timescale 1ns/1ps
// Board around the pads: external drivers, pull-ups and floating lines
module pafm_board (
  input wire logic clk_i,
  input wire logic [27:0] pad_out_i, // Level the device drives
  input wire logic [27:0] pad_oe_i, // Device drives the line
  input wire logic [27:0] pull_i, // Weak pull-up switched on
  input wire logic [27:0] ext_drv_i, // Board circuit drives the line
  input wire logic [27:0] ext_val_i, // Level the board drives
  output logic [27:0] pad_o
);
  logic [27:0] flt_r; // Wandering level, so a stale value never passes for a drive
  // Floating lines toggle every cycle
  initial begin
    flt_r = 28'h0;
    forever @(posedge clk_i) flt_r <= ~flt_r;
  end
  // Device drive wins, then the board, then the pull-up
  always_comb begin
    for (int i = 0; i < 28; i++) begin
      if (pad_oe_i[i]) pad_o[i] = pad_out_i[i];
      else if (ext_drv_i[i]) pad_o[i] = ext_val_i[i];
      else if (pull_i[i]) pad_o[i] = 1'b1;
      else pad_o[i] = flt_r[i];
    end
  end
endmodule

/* test/tb.sv */
`timescale 1ns/1ps
`include "pafm_params.svh"
module tb;
  logic clk, rst, hsel, hwrite; // Clock, reset, bus controls
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata;
  wire logic [31:0] hrdata;
  wire logic hready, hresp, nmi, trg, sdi;
  wire logic [27:0] pad_in, pad_out, pad_oe, pad_pu, pad_cmos, pad_ana;
  wire logic [7:0] irq;
  wire logic [3:0] ain;
  logic [7:0] pwm, irq_en; // PWM levels, interrupt enables
  // 0 tune1, 1 tune2, 2 transl, 3 halftone, 4 timer, 5 int reset, 6 sync,
  // 7 spi clock, 8 spi data, 9 spi transmit
  logic [9:0] per;
  logic nmi_en, trg_en, spi_en;
  logic [27:0] ext_drv, ext_val; // Board drive per line
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  pafm_top i_pafm_top (.CORE_CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .PAD_IN_I(pad_in), .PAD_OUT_O(pad_out), .PAD_OE_O(pad_oe), .PAD_PULLUP_O(pad_pu),
    .PAD_CMOS_O(pad_cmos), .PAD_ANALOG_O(pad_ana), .PULSE_WIDTH_OUT_I(pwm),
    .TUNING_VOLTAGE_OUT_1_I(per[0]), .TUNING_VOLTAGE_OUT_2_I(per[1]),
    .TRANSLUCENCY_OUT_I(per[2]), .HALFTONE_OUT_I(per[3]), .TIMER_OUT_I(per[4]),
    .INTERNAL_RESET_OUT_I(per[5]), .COMPOSITE_SYNC_OUT_I(per[6]), .SPI_CLK_I(per[7]),
    .SPI_DOUT_I(per[8]), .SPI_DOUT_EN_I(per[9]), .EXT_IRQ_EN_I(irq_en), .NMI_EN_I(nmi_en),
    .TRIGGER_EN_I(trg_en), .SPI_EN_I(spi_en), .EXT_IRQ_O(irq), .NMI_O(nmi),
    .CONVERTER_TRIGGER_IN_O(trg), .SPI_DIN_O(sdi), .ANALOG_IN_SEL_O(ain));
  pafm_board i_pafm_board (.clk_i(clk), .pad_out_i(pad_out), .pad_oe_i(pad_oe),
    .pull_i(pad_pu), .ext_drv_i(ext_drv), .ext_val_i(ext_val), .pad_o(pad_in));
  // Free-running core clock, 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard: generous against about 170 cycles of traffic
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      conclude();
    end
  end
  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Compare with case equality so unknowns fail
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Let edges pass, then sample where outputs have settled
  task wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Single word write: address phase, then data phase, each held until ready
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; haddr <= a; hwrite <= 1'b1; htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
  endtask
  // Single word read, data taken at the edge ending the data phase
  task rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    hsel <= 1'b1; haddr <= a; hwrite <= 1'b0; htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0;
    do @(posedge clk); while (hready !== 1'b1);
    chk(nm, e, hrdata);
  endtask
  // High, then middle, then low; a half-written code can briefly make a line push-pull
  task cfg(input logic [27:0] hi, input logic [27:0] mid, input logic [27:0] lo);
    wr(`PAFM_OFS_CFG_HIGH, {4'h0, hi});
    wr(`PAFM_OFS_CFG_MID, {4'h0, mid});
    wr(`PAFM_OFS_CFG_LOW, {4'h0, lo});
  endtask
  task t_reset;
    wait_n(2);
    chk("oe", 28'h0020000, pad_oe);
    chk("out", 28'h0020000, pad_out);
    chk("styles", 0, pad_cmos | pad_pu | pad_ana);
    chk("ain", 0, ain);
    chk("hresp", 0, hresp);
    rchk("out_data", `PAFM_OFS_OUT_DATA, 32'h0fffffff);
    rchk("cfg_low", `PAFM_OFS_CFG_LOW, 32'h00020000);
    rchk("cfg_mid", `PAFM_OFS_CFG_MID, 32'h00020000);
    rchk("cfg_high", `PAFM_OFS_CFG_HIGH, 32'h0);
    rchk("af_sel", `PAFM_OFS_AF_SEL, 32'h0);
    wr(32'h1c, 32'hffffffff);
    rchk("unmapped", 32'h1c, 32'h0);
  endtask
  task t_pullup;
    wr(`PAFM_OFS_PULLUP_EN, 32'h0fffffff);
    rchk("pullup_en", `PAFM_OFS_PULLUP_EN, 32'h00020000);
    wait_n(1);
    chk("pad_pu", 28'h0020000, pad_pu);
    wr(`PAFM_OFS_PULLUP_EN, 32'h0);
    wait_n(2);
    chk("pad_pu_off", 0, pad_pu);
  endtask
  // One board pattern through the interrupt, NMI, trigger and pin-input routes
  task irq_pat(input logic [27:0] v);
    @(posedge clk);
    ext_val <= v;
    wait_n(6);
    chk("irq", {v[8], v[11], v[9], v[13], 1'b0, v[26], 1'b0, v[10]}, irq);
    chk("nmi_trg", {v[12], v[25]}, {nmi, trg});
    rchk("pin_in", `PAFM_OFS_PIN_IN, {4'h0, v[27:18], 1'b1, v[16:0]});
  endtask
  task t_irq;
    cfg(28'h2000000, 28'h0020000, 28'h2020000);
    @(posedge clk);
    irq_en <= 8'hff; nmi_en <= 1'b1; trg_en <= 1'b1; ext_drv <= 28'hfffffff;
    irq_pat(28'h5a5a5a5);
    irq_pat(28'ha5a5a5a);
    chk("ttl", 0, pad_cmos[25]);
    @(posedge clk);
    irq_en <= 8'h0; nmi_en <= 1'b0; trg_en <= 1'b0;
    wait_n(6);
    chk("irq_off", 0, {irq, nmi, trg});
  endtask
  task t_analog;
    cfg(0, 28'hfffffff, 0);
    wait_n(1);
    chk("cmos", 28'hffffcff, pad_cmos);
    @(posedge clk);
    ext_val <= 28'hfffffff; irq_en <= 8'hff;
    cfg(28'h0002604, 28'h0002604, 28'h0002604);
    wait_n(6);
    chk("ain", 4'hf, ain);
    chk("ana", 28'h0002604, pad_ana);
    chk("ana_cut", 8'h01, {pad_oe[13], pad_oe[10], pad_oe[9], pad_oe[2],
      irq[5], irq[0], irq[4], irq[7]});
  endtask
  // Select an alternate source and judge P4.7, P4.3 and P3.7 together
  task af(input logic [3:0] sel, input logic [4:0] p, input logic [2:0] e);
    @(posedge clk);
    per[6:2] <= p;
    wr(`PAFM_OFS_AF_SEL, {28'h0, sel});
    wait_n(2);
    chk("af_pins", e, {pad_out[25], pad_out[21], pad_out[17]});
  endtask
  task t_pwm;
    @(posedge clk);
    irq_en <= 8'h0; ext_drv <= 28'h0;
    cfg(0, 28'hffe2800, 28'hffe2800);
    #1;
    chk("oe_old", 0, pad_oe[25:18]);
    wait_n(1);
    chk("oe_new", 28'hffe2800, pad_oe);
    chk("pwm", 8'ha5, pad_out[25:18]);
    chk("tuning", 2'b01, {pad_out[13], pad_out[11]});
    chk("spi_out", 2'b01, {pad_out[27], pad_out[26]});
    af(4'h2, 5'b01001, 3'b111);
    af(4'h4, 5'b01010, 3'b111);
    af(4'h6, 5'b01011, 3'b101);
    af(4'h8, 5'b01000, 3'b001);
    af(4'h1, 5'b10000, 3'b101);
  endtask
  // Shared data line turns round to receive
  task t_spi;
    @(posedge clk);
    per[9] <= 1'b0; spi_en <= 1'b1; ext_drv <= 28'h8000000; ext_val <= 28'h8000000;
    wait_n(6);
    chk("spi_in", 2'b01, {pad_oe[27], sdi});
    @(posedge clk);
    ext_val <= 28'h0;
    wait_n(6);
    chk("spi_in_low", 0, sdi);
  endtask
  initial begin
    rst = 1'b1; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0; haddr = 0; hwdata = 0;
    pwm = 8'ha5; irq_en = 8'h0; per = 10'h2ad; nmi_en = 1'b0; trg_en = 1'b0;
    spi_en = 1'b0; ext_drv = 28'h0; ext_val = 28'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_pullup();
    t_irq();
    t_analog();
    t_pwm();
    t_spi();
    conclude();
  end
endmodule
